/* modbus_port_pkg.sv */
package modbus_port_pkg;

  // Core clock
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned BAUD_MIN_HZ  = 300;
  // Divider for the slowest rate, rounded to nearest
  localparam int unsigned DIV_300_DFLT =
    (CLK_HZ + OVERSAMPLE * BAUD_MIN_HZ / 2) / (OVERSAMPLE * BAUD_MIN_HZ);

  // Register byte offsets
  localparam logic [7:0] OFS_CARD   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_BAUD   = 8'h08;
  localparam logic [7:0] OFS_PARITY = 8'h0C;
  localparam logic [7:0] OFS_ORDER  = 8'h10;
  localparam logic [7:0] OFS_TXDATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Option card codes (serial_module_choice)
  localparam logic [2:0] CARD_NONE   = 3'h0;
  localparam logic [2:0] CARD_SERIAL = 3'h6;
  localparam logic [2:0] CARD_MAX    = 3'h6;

  // Station address limits and reset
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] ADDR_RST = 8'h01;

  // Baud codes 0..5 = 300,600,1200,2400,4800,9600
  localparam logic [2:0] BAUD_MAX = 3'h5;
  localparam logic [2:0] BAUD_RST = 3'h5;

  // Parity codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_RST  = PAR_NONE;

  // Float word order: 1 = low register first
  localparam logic ORDER_RST = 1'b1;

  // Character framing and inter-frame gap
  localparam logic [3:0] DATA_BITS  = 4'h8;
  localparam logic [3:0] SUB_LAST   = 4'hF;
  localparam logic [3:0] SUB_MID    = 4'h7;
  localparam logic [9:0] GAP_TICKS  = 10'h230;  // 3.5 chars of 10 bits, x16
  localparam logic [2:0] TX_BYTES   = 3'h4;

  // Status bit positions
  localparam int unsigned ST_RXVALID = 8;
  localparam int unsigned ST_MATCH   = 9;
  localparam int unsigned ST_TXBUSY  = 10;
  localparam int unsigned ST_SERIAL  = 11;

  // Line state machines
  typedef enum logic [3:0] {
    LN_IDLE  = 4'b0001,
    LN_START = 4'b0010,
    LN_DATA  = 4'b0100,
    LN_STOP  = 4'b1000
  } line_state_t;

endpackage : modbus_port_pkg

/* baud_tick.sv */
`timescale 1ns/1ns
// Oversampling tick generator: one pulse every DIV_300 >> rate_code cycles
module baud_tick #(
  parameter int unsigned DIV_300 = modbus_port_pkg::DIV_300_DFLT
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Rate selection
  input  wire logic [2:0] rate_code,
  // Oversample tick
  output logic            tick_q
);

  logic [15:0] cnt_q;    // Cycle counter
  logic [15:0] limit;    // Terminal count for current rate

  // Each step of the code doubles the rate, so halve the divider
  assign limit = 16'(DIV_300 >> rate_code) - 16'h0001;

  // Counter restarts when the rate changes past the new limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

endmodule : baud_tick

/* modbus_port.sv */
`timescale 1ns/1ns
module modbus_port #(
  parameter int unsigned DIV_300 = modbus_port_pkg::DIV_300_DFLT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready_q,
  output logic             pslverr_q,
  output logic [31:0]      prdata_q,
  // Serial line
  input  wire logic        rxd,
  output logic             txd_q
);

  logic [2:0]  card_q;          // serial_module_choice
  logic [7:0]  addr_q;          // Station address
  logic [2:0]  baud_q;          // Rate code
  logic [1:0]  par_q;           // Parity choice
  logic        order_q;         // float_word_order_select
  logic        serial_en;       // Serial card selected
  logic        acc_done;        // Completing access
  logic        wr_en;           // Write takes effect
  logic        rd_status;       // Status read completes
  logic        mapped;          // Address decodes
  logic        tick;            // Oversample tick
  logic        rxd_m_q;         // Sync stage 1
  logic        rxd_s_q;         // Sync stage 2
  modbus_port_pkg::line_state_t rx_st_q;  // Receiver state
  logic [3:0]  rx_sub_q;        // Tick within bit
  logic [3:0]  rx_bits_q;       // Data bits taken
  logic [7:0]  rx_sh_q;         // Receive shifter
  logic        rx_done;         // Good character ends
  logic [9:0]  gap_q;           // Idle ticks
  logic        expect_addr_q;   // Next char is address
  logic        match_q;         // Frame is for us
  logic [7:0]  rx_data_q;       // Last delivered byte
  logic        rx_valid_q;      // Sticky byte flag
  modbus_port_pkg::line_state_t tx_st_q;  // Transmitter state
  logic [3:0]  tx_sub_q;        // Tick within bit
  logic [3:0]  tx_bits_q;       // Data bits sent
  logic [2:0]  tx_left_q;       // Bytes left
  logic [31:0] tx_buf_q;        // Byte queue, first byte on top
  logic        tx_load;         // Accept a float

  assign serial_en = (card_q == modbus_port_pkg::CARD_SERIAL);
  assign acc_done  = psel && penable && pready_q;
  assign wr_en     = acc_done && pwrite;
  assign rd_status = acc_done && !pwrite && (paddr == modbus_port_pkg::OFS_STATUS);
  assign mapped    = (paddr <= modbus_port_pkg::OFS_STATUS) && (paddr[1:0] == 2'h0);
  // A reply is only allowed to a frame that named us
  // The idle cycle between two bytes of a reply must not restart the sender
  assign tx_load   = wr_en && (paddr == modbus_port_pkg::OFS_TXDATA) && serial_en
                     && match_q && (tx_st_q == modbus_port_pkg::LN_IDLE)
                     && (tx_left_q == 3'h0);

  // Rate tick for both directions
  baud_tick #(.DIV_300(DIV_300)) u_tick (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .rate_code (baud_q),
    .tick_q    (tick)
  );

  // Bus answer: one wait state, then ready with data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q && !pwrite) begin
        unique case (paddr)
          modbus_port_pkg::OFS_CARD:   prdata_q <= {29'h0, card_q};
          // Serial settings read zero while hidden
          modbus_port_pkg::OFS_ADDR:   prdata_q <= serial_en ? {24'h0, addr_q} : 32'h0;
          modbus_port_pkg::OFS_BAUD:   prdata_q <= serial_en ? {29'h0, baud_q} : 32'h0;
          modbus_port_pkg::OFS_PARITY: prdata_q <= serial_en ? {30'h0, par_q} : 32'h0;
          modbus_port_pkg::OFS_ORDER:  prdata_q <= serial_en ? {31'h0, order_q} : 32'h0;
          modbus_port_pkg::OFS_STATUS: prdata_q <= {20'h0, serial_en,
                                                    tx_st_q != modbus_port_pkg::LN_IDLE,
                                                    match_q, rx_valid_q, rx_data_q};
          default:                     prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Option card selector; codes above CARD_MAX are ignored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_q <= modbus_port_pkg::CARD_NONE;
    end else if (wr_en && paddr == modbus_port_pkg::OFS_CARD
                 && pwdata[2:0] <= modbus_port_pkg::CARD_MAX) begin
      card_q <= pwdata[2:0];
    end
  end

  // Serial settings: writable only with serial card, out-of-range values dropped except word order, which takes bit 0
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q  <= modbus_port_pkg::ADDR_RST;
      baud_q  <= modbus_port_pkg::BAUD_RST;
      par_q   <= modbus_port_pkg::PAR_RST;
      order_q <= modbus_port_pkg::ORDER_RST;
    end else if (wr_en && serial_en) begin
      if (paddr == modbus_port_pkg::OFS_ADDR && pwdata[31:8] == 24'h0
          && pwdata[7:0] >= modbus_port_pkg::ADDR_MIN
          && pwdata[7:0] <= modbus_port_pkg::ADDR_MAX) begin
        addr_q <= pwdata[7:0];
      end
      if (paddr == modbus_port_pkg::OFS_BAUD && pwdata[31:3] == 29'h0
          && pwdata[2:0] <= modbus_port_pkg::BAUD_MAX) begin
        baud_q <= pwdata[2:0];
      end
      if (paddr == modbus_port_pkg::OFS_PARITY && pwdata[31:2] == 30'h0
          && pwdata[1:0] != 2'h3) begin
        par_q <= pwdata[1:0];
      end
      if (paddr == modbus_port_pkg::OFS_ORDER) begin
        order_q <= pwdata[0];
      end
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // Character ends with a high stop bit sampled mid-bit
  assign rx_done = tick && (rx_st_q == modbus_port_pkg::LN_STOP)
                   && (rx_sub_q == modbus_port_pkg::SUB_LAST) && rxd_s_q;

  // Receiver: fixed 10-bit character regardless of parity choice
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q   <= modbus_port_pkg::LN_IDLE;
      rx_sub_q  <= 4'h0;
      rx_bits_q <= 4'h0;
      rx_sh_q   <= 8'h00;
    end else if (!serial_en) begin
      rx_st_q <= modbus_port_pkg::LN_IDLE;
    end else begin
      unique case (rx_st_q)
        modbus_port_pkg::LN_IDLE: begin
          rx_sub_q  <= 4'h0;
          rx_bits_q <= 4'h0;
          if (!rxd_s_q) begin
            rx_st_q <= modbus_port_pkg::LN_START;
          end
        end
        modbus_port_pkg::LN_START: begin
          if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            // Glitch shorter than half a bit is not a start
            if (rx_sub_q == modbus_port_pkg::SUB_MID) begin
              rx_sub_q <= 4'h0;
              rx_st_q  <= rxd_s_q ? modbus_port_pkg::LN_IDLE : modbus_port_pkg::LN_DATA;
            end
          end
        end
        modbus_port_pkg::LN_DATA: begin
          if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == modbus_port_pkg::SUB_LAST) begin
              rx_sh_q   <= {rxd_s_q, rx_sh_q[7:1]};
              rx_bits_q <= rx_bits_q + 4'h1;
              if (rx_bits_q == modbus_port_pkg::DATA_BITS - 4'h1) begin
                rx_st_q <= modbus_port_pkg::LN_STOP;
              end
            end
          end
        end
        modbus_port_pkg::LN_STOP: begin
          if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            // Framing errors are dropped silently
            if (rx_sub_q == modbus_port_pkg::SUB_LAST) begin
              rx_st_q <= modbus_port_pkg::LN_IDLE;
            end
          end
        end
        default: rx_st_q <= modbus_port_pkg::LN_IDLE;
      endcase
    end
  end

  // Silent-line timer marks the start of a new frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q         <= 10'h000;
      expect_addr_q <= 1'b1;
    end else if (rx_st_q != modbus_port_pkg::LN_IDLE || !rxd_s_q) begin
      gap_q <= 10'h000;
      if (rx_done) begin
        expect_addr_q <= 1'b0;
      end
    end else if (tick && gap_q != modbus_port_pkg::GAP_TICKS) begin
      gap_q <= gap_q + 10'h001;
      if (gap_q == modbus_port_pkg::GAP_TICKS - 10'h001) begin
        expect_addr_q <= 1'b1;
      end
    end
  end

  // Address filter and byte delivery; a new byte wins over a status read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_q    <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      if (rx_done && expect_addr_q) begin
        match_q <= (rx_sh_q == addr_q);
      end
      if (rx_done && !expect_addr_q && match_q) begin
        rx_data_q  <= rx_sh_q;
        rx_valid_q <= 1'b1;
      end else if (rd_status) begin
        rx_valid_q <= 1'b0;
      end
    end
  end

  // Transmitter: four bytes, word order from the select bit, big-endian words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_q   <= modbus_port_pkg::LN_IDLE;
      tx_sub_q  <= 4'h0;
      tx_bits_q <= 4'h0;
      tx_left_q <= 3'h0;
      tx_buf_q  <= 32'h0000_0000;
      txd_q     <= 1'b1;
    end else begin
      unique case (tx_st_q)
        modbus_port_pkg::LN_IDLE: begin
          txd_q <= 1'b1;
          if (tx_load) begin
            tx_buf_q  <= order_q ? {pwdata[15:0], pwdata[31:16]} : pwdata;
            tx_left_q <= modbus_port_pkg::TX_BYTES;
            tx_st_q   <= modbus_port_pkg::LN_START;
          end else if (tx_left_q != 3'h0) begin
            tx_st_q <= modbus_port_pkg::LN_START;
          end
          tx_sub_q  <= 4'h0;
          tx_bits_q <= 4'h0;
        end
        modbus_port_pkg::LN_START: begin
          txd_q <= 1'b0;
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == modbus_port_pkg::SUB_LAST) begin
              tx_st_q <= modbus_port_pkg::LN_DATA;
            end
          end
        end
        modbus_port_pkg::LN_DATA: begin
          txd_q <= tx_buf_q[24 + int'(tx_bits_q[2:0])];
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == modbus_port_pkg::SUB_LAST) begin
              tx_bits_q <= tx_bits_q + 4'h1;
              if (tx_bits_q == modbus_port_pkg::DATA_BITS - 4'h1) begin
                tx_st_q <= modbus_port_pkg::LN_STOP;
              end
            end
          end
        end
        modbus_port_pkg::LN_STOP: begin
          txd_q <= 1'b1;
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == modbus_port_pkg::SUB_LAST) begin
              tx_buf_q  <= {tx_buf_q[23:0], 8'h00};
              tx_left_q <= tx_left_q - 3'h1;
              tx_st_q   <= modbus_port_pkg::LN_IDLE;
            end
          end
        end
        default: tx_st_q <= modbus_port_pkg::LN_IDLE;
      endcase
    end
  end

  // Checks
  sequence apb_wait;
    psel && penable && !pready_q;
  endsequence

  chk_apb_answer: assert property (@(posedge clk) disable iff (sys_rst)
    apb_wait |=> pready_q) else $error("APB answer late");
  chk_card_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_en && !serial_en) |=> $stable(addr_q) && $stable(baud_q))
    else $error("Hidden setting changed");
  chk_addr_range: assert property (@(posedge clk) disable iff (sys_rst)
    addr_q >= 8'h01 && addr_q <= 8'hF7) else $error("Address out of range");
  chk_baud_code: assert property (@(posedge clk) disable iff (sys_rst)
    baud_q <= 3'h5) else $error("Bad rate code");
  chk_parity_code: assert property (@(posedge clk) disable iff (sys_rst)
    par_q != 2'h3) else $error("Bad parity code");
  chk_stop_high: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(tx_st_q == modbus_port_pkg::LN_STOP) |-> tx_bits_q == 4'h8 ##1 txd_q)
    else $error("Stop bit wrong");
  chk_word_order: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_load && order_q) |=> tx_buf_q[31:16] == $past(pwdata[15:0]))
    else $error("Low word not first");
  chk_rx_filter: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(rx_valid_q) |-> match_q) else $error("Foreign frame delivered");
  chk_reply_gate: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(tx_st_q == modbus_port_pkg::LN_START) && $past(tx_left_q) == 3'h0
    |-> $past(match_q)) else $error("Reply without match");

endmodule : modbus_port

/* modbus_master_model.sv */
`timescale 1ns/1ns
// Behavioural bus master on the far side of the serial line
module modbus_master_model (
  // Clock
  input  wire logic clk,
  // Bit time in clk cycles, set by the bench
  input  int        bit_cyc,
  // Serial lines
  input  wire logic dev_txd,
  output logic      dev_rxd,
  // Observation counters
  output int        tx_falls,
  output int        stop_errs
);
  // Line idles high between frames
  initial begin
    dev_rxd   = 1'b1;
    tx_falls  = 0;
    stop_errs = 0;
  end

  // Count every falling edge the device sends, start or data bit, wanted or not
  always @(negedge dev_txd) begin
    tx_falls = tx_falls + 1;
  end

  // Silence of 570 ticks, above the 560-tick frame gap
  task automatic send_gap;
    repeat (570 * bit_cyc / 16) @(posedge clk);
  endtask : send_gap

  // One start, eight data LSB first, one stop, never a parity bit
  task automatic send_byte(input logic [7:0] b);
    dev_rxd <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      dev_rxd <= b[i];
      repeat (bit_cyc) @(posedge clk);
    end
    dev_rxd <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask : send_byte

  // Receive one character at the same rate as the device
  task automatic recv_byte(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hFF;
    // Bounded wait for the start bit
    while (dev_txd !== 1'b0 && n < 64 * bit_cyc) begin
      @(posedge clk);
      n++;
    end
    if (n >= 64 * bit_cyc) begin
      stop_errs++;
    end else begin
      // Sample near mid bit to tolerate a cycle of skew
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk);
        b[i] = dev_txd;
      end
      repeat (bit_cyc) @(posedge clk);
      // A parity bit would land here instead of the stop bit
      if (dev_txd !== 1'b1) begin
        stop_errs++;
      end
    end
  endtask : recv_byte
endmodule : modbus_master_model

/* modbus_serial_port_setup_test.sv */
`timescale 1ns/1ns
module modbus_serial_port_setup_test;
  // Short divider so the slow rates fit the run
  localparam int unsigned DIV = 32;
  // Design-side signals
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        rxd;
  logic        txd_q;
  // Bench state
  int          bit_cyc;
  int          tx_falls;
  int          stop_errs;
  int          error_cnt;
  int          checks;
  int          f;
  logic [31:0] rdv;
  logic        err;
  // Writes: offset, value, expected read-back
  logic [23:0] tbl [15] = '{24'h00_07_06, 24'h00_03_03, 24'h04_05_00, 24'h00_06_06,
                            24'h04_00_01, 24'h04_F8_01, 24'h04_F7_F7, 24'h04_05_05,
                            24'h08_06_05, 24'h08_07_05, 24'h0C_03_00, 24'h0C_02_02,
                            24'h0C_01_01, 24'h10_00_00, 24'h10_01_01};

  modbus_port #(.DIV_300(DIV)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .prdata_q(prdata_q), .rxd(rxd), .txd_q(txd_q));

  modbus_master_model mm (
    .clk(clk), .bit_cyc(bit_cyc), .dev_txd(txd_q), .dev_rxd(rxd),
    .tx_falls(tx_falls), .stop_errs(stop_errs));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdv, err);
    check(rdv & m, e);
  endtask : rd_chk

  // Send a float and collect its four bytes in the selected order
  task automatic tx_chk(input logic [31:0] d, input int o);
    logic [7:0] b;
    wr(8'h14, d);
    for (int k = 0; k < 4; k++) begin
      mm.recv_byte(b);
      check({24'h0, b}, (d >> (8 * (3 - (o != 0 ? k ^ 2 : k)))) & 32'hFF);
    end
    // Let the last stop bit finish before the next request
    repeat (bit_cyc) @(posedge clk);
  endtask : tx_chk

  // Summary and verdict; the only exit of the run
  task automatic give_verdict;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Watchdog: the run needs about 82k cycles, the slowest rate dominating
  initial begin
    #(8 * 98000);
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    bit_cyc = 16;
    error_cnt = 0;
    checks    = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // No serial card: settings hidden, receiver and sender idle
    rd_chk(8'h00, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h04, 32'hFFFFFFFF, 32'h0);
    mm.send_gap();
    mm.send_byte(8'h01);
    rd_chk(8'h18, 32'hF00, 32'h0);
    f = tx_falls;
    wr(8'h14, 32'h12345678);
    repeat (200) @(posedge clk);
    check(tx_falls, f);
    // Serial card: defaults become visible
    wr(8'h00, 32'h6);
    rd_chk(8'h04, 32'hFFFFFFFF, 32'h1);
    rd_chk(8'h08, 32'hFFFFFFFF, 32'h5);
    rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h10, 32'hFFFFFFFF, 32'h1);
    rd_chk(8'h18, 32'h800, 32'h800);
    // Boundary and out-of-range settings
    for (int i = 0; i < 15; i++) begin
      wr(tbl[i][23:16], {24'h0, tbl[i][15:8]});
      rd_chk(tbl[i][23:16], 32'hFFFFFFFF, {24'h0, tbl[i][7:0]});
    end
    // Unmapped and unaligned places are refused
    apb(1'b0, 8'h1C, 32'h0, rdv, err);
    check({31'h0, err}, 32'h1);
    apb(1'b1, 8'h02, 32'h0, rdv, err);
    check({31'h0, err}, 32'h1);
    // Frame for own address is taken, valid clears on read
    mm.send_gap();
    mm.send_byte(8'h05);
    mm.send_byte(8'hA5);
    rd_chk(8'h18, 32'h3FF, 32'h3A5);
    rd_chk(8'h18, 32'h100, 32'h0);
    // Every parity and both word orders keep ten-bit characters
    for (int p = 0; p < 3; p++) begin
      for (int o = 0; o < 2; o++) begin
        wr(8'h0C, 32'(p));
        wr(8'h10, 32'(o));
        tx_chk(32'h01807F3C, o);
      end
    end
    // Frame for another station: no match, no reply
    mm.send_gap();
    mm.send_byte(8'h06);
    rd_chk(8'h18, 32'h200, 32'h0);
    f = tx_falls;
    wr(8'h14, 32'h12345678);
    repeat (200) @(posedge clk);
    check(tx_falls, f);
    // Every slower rate both ways; the slowest receive only
    for (int c = 4; c >= 0; c--) begin
      wr(8'h08, 32'(c));
      rd_chk(8'h08, 32'hFFFFFFFF, 32'(c));
      bit_cyc = 16 * (DIV >> c);
      mm.send_gap();
      // The address byte is never delivered, so a data byte follows it
      mm.send_byte(8'h05);
      mm.send_byte(8'hA0 | 8'(c));
      repeat (4) @(posedge clk);
      rd_chk(8'h18, 32'h3FF, 32'h3A0 | 32'(c));
      if (c > 0) begin
        tx_chk(32'hC3A55A0F, 1);
      end
    end
    check(stop_errs, 0);
    give_verdict();
  end
endmodule : modbus_serial_port_setup_test
